// ===== rtl/atd_top.sv
`timescale 1ns/100ps
module atd_top
    import atd_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // instruction from the core sequencer, one-cycle valid per instruction cycle
    input wire logic INSTR_VALID,
    input wire logic [ATD_WORD_W-1:0] INSTR_WORD,
    // source registers
    input wire logic [ATD_NIB_W-1:0] ACC_DATA,
    input wire logic [ATD_NIB_W-1:0] REG_B_DATA,
    // register e
    output logic [ATD_E_W-1:0] REG_E,
    output logic REG_E_WR,
    // output-structure control registers
    output logic [ATD_NIB_W-1:0] PORT_OUTCFG_REG0,
    output logic [ATD_NIB_W-1:0] PORT_OUTCFG_REG1,
    output logic PORT_OUTCFG_REG0_WR,
    output logic PORT_OUTCFG_REG1_WR,
    // flow control towards the core
    output logic EXEC_DONE,
    output logic CARRY_FLAG_WE,
    output logic SKIP_NEXT
);
    atd_dec_if dif ();
    logic [ATD_E_W-1:0] reg_e_r;
    logic [ATD_NIB_W-1:0] outcfg0_r;
    logic [ATD_NIB_W-1:0] outcfg1_r;
    logic e_wr_r;
    logic f0_wr_r;
    logic f1_wr_r;
    logic done_r;
    logic carry_we_r;
    logic skip_r;
    logic hit;

    assign dif.word = INSTR_WORD;
    assign dif.valid = INSTR_VALID;
    assign hit = (dif.sel != ATD_SEL_NONE);

    atd_decode u_dec (
        .dif(dif.dec)
    );

    // ----------------------------------------
    // register e
    // ----------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            reg_e_r <= ATD_E_RST;
        end else if (dif.sel == ATD_SEL_PACK_E) begin
            reg_e_r[ATD_E_HI_LSB +: ATD_NIB_W] <= REG_B_DATA;
            reg_e_r[ATD_E_LO_LSB +: ATD_NIB_W] <= ACC_DATA;
        end
    end

    // ----------------------------------------
    // output-structure control registers
    // ----------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            outcfg0_r <= ATD_OUTCFG_RST;
        end else if (dif.sel == ATD_SEL_OUTCFG0) begin
            outcfg0_r <= ACC_DATA;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            outcfg1_r <= ATD_OUTCFG_RST;
        end else if (dif.sel == ATD_SEL_OUTCFG1) begin
            outcfg1_r <= ACC_DATA;
        end
    end

    // ----------------------------------------
    // strobes, registered on the executing edge together with the data
    // ----------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            e_wr_r <= 1'b0;
            f0_wr_r <= 1'b0;
            f1_wr_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            e_wr_r <= (dif.sel == ATD_SEL_PACK_E);
            f0_wr_r <= (dif.sel == ATD_SEL_OUTCFG0);
            f1_wr_r <= (dif.sel == ATD_SEL_OUTCFG1);
            done_r <= hit;
        end
    end

    // ----------------------------------------
    // flow control
    // ----------------------------------------
    // held low: these transfers never request a carry write or a skip,
    // so the core just advances to the next word
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            carry_we_r <= 1'b0;
            skip_r <= 1'b0;
        end else if (hit) begin
            carry_we_r <= 1'b0;
            skip_r <= 1'b0;
        end
    end

    assign REG_E = reg_e_r;
    assign REG_E_WR = e_wr_r;
    assign PORT_OUTCFG_REG0 = outcfg0_r;
    assign PORT_OUTCFG_REG1 = outcfg1_r;
    assign PORT_OUTCFG_REG0_WR = f0_wr_r;
    assign PORT_OUTCFG_REG1_WR = f1_wr_r;
    assign EXEC_DONE = done_r;
    assign CARRY_FLAG_WE = carry_we_r;
    assign SKIP_NEXT = skip_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    property p_pack_decode;
        INSTR_VALID && INSTR_WORD == ATD_OP_PACK_E |=> REG_E_WR && EXEC_DONE;
    endproperty
    a_pack_decode: assert property (p_pack_decode) else $error("pack not taken");

    property p_pack_hi;
        INSTR_VALID && INSTR_WORD == ATD_OP_PACK_E |=>
            REG_E[ATD_E_HI_LSB +: ATD_NIB_W] == $past(REG_B_DATA);
    endproperty
    a_pack_hi: assert property (p_pack_hi) else $error("e high nibble wrong");

    property p_pack_lo;
        INSTR_VALID && INSTR_WORD == ATD_OP_PACK_E |=>
            REG_E[ATD_E_LO_LSB +: ATD_NIB_W] == $past(ACC_DATA);
    endproperty
    a_pack_lo: assert property (p_pack_lo) else $error("e low nibble wrong");

    property p_cfg0_decode;
        INSTR_VALID && INSTR_WORD == ATD_OP_OUTCFG0 |=>
            PORT_OUTCFG_REG0_WR && !PORT_OUTCFG_REG1_WR;
    endproperty
    a_cfg0_decode: assert property (p_cfg0_decode) else $error("cfg0 not taken");

    property p_cfg0_data;
        INSTR_VALID && INSTR_WORD == ATD_OP_OUTCFG0 |=> PORT_OUTCFG_REG0 == $past(ACC_DATA);
    endproperty
    a_cfg0_data: assert property (p_cfg0_data) else $error("cfg0 data wrong");

    property p_cfg1_decode;
        INSTR_VALID && INSTR_WORD == ATD_OP_OUTCFG1 |=>
            PORT_OUTCFG_REG1_WR && !PORT_OUTCFG_REG0_WR;
    endproperty
    a_cfg1_decode: assert property (p_cfg1_decode) else $error("cfg1 not taken");

    property p_cfg1_data;
        INSTR_VALID && INSTR_WORD == ATD_OP_OUTCFG1 |=> PORT_OUTCFG_REG1 == $past(ACC_DATA);
    endproperty
    a_cfg1_data: assert property (p_cfg1_data) else $error("cfg1 data wrong");

    property p_no_side;
        EXEC_DONE |-> !CARRY_FLAG_WE && !SKIP_NEXT;
    endproperty
    a_no_side: assert property (p_no_side) else $error("carry or skip touched");

    property p_e_hold;
        !REG_E_WR |-> $stable(REG_E);
    endproperty
    a_e_hold: assert property (p_e_hold) else $error("e changed without pack");

    property p_cfg_hold;
        !(INSTR_VALID && INSTR_WORD == ATD_OP_OUTCFG0) |=> $stable(PORT_OUTCFG_REG0);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("cfg0 changed spuriously");

    property p_cfg1_hold;
        !(INSTR_VALID && INSTR_WORD == ATD_OP_OUTCFG1) |=> $stable(PORT_OUTCFG_REG1);
    endproperty
    a_cfg1_hold: assert property (p_cfg1_hold) else $error("cfg1 changed spuriously");

    // a near-miss word or a dropped valid must look exactly like an idle cycle
    property p_refuse;
        !(INSTR_VALID && (INSTR_WORD == ATD_OP_PACK_E || INSTR_WORD == ATD_OP_OUTCFG0
            || INSTR_WORD == ATD_OP_OUTCFG1)) |=>
            !EXEC_DONE && !REG_E_WR && !PORT_OUTCFG_REG0_WR && !PORT_OUTCFG_REG1_WR;
    endproperty
    a_refuse: assert property (p_refuse) else $error("stray pulse");

    property p_flow_idle;
        !CARRY_FLAG_WE && !SKIP_NEXT;
    endproperty
    a_flow_idle: assert property (p_flow_idle) else $error("carry or skip raised");

    property p_cfg0_keeps_e;
        INSTR_VALID && INSTR_WORD == ATD_OP_OUTCFG0 |=> !REG_E_WR && $stable(REG_E);
    endproperty
    a_cfg0_keeps_e: assert property (p_cfg0_keeps_e) else $error("cfg0 touched e");

    property p_cfg1_keeps_rest;
        INSTR_VALID && INSTR_WORD == ATD_OP_OUTCFG1 |=>
            $stable(REG_E) && $stable(PORT_OUTCFG_REG0);
    endproperty
    a_cfg1_keeps_rest: assert property (p_cfg1_keeps_rest) else $error("cfg1 touched more");

    property p_pack_keeps_cfg;
        INSTR_VALID && INSTR_WORD == ATD_OP_PACK_E |=>
            $stable(PORT_OUTCFG_REG0) && $stable(PORT_OUTCFG_REG1);
    endproperty
    a_pack_keeps_cfg: assert property (p_pack_keeps_cfg) else $error("pack touched cfg");

    // one of each transfer, a refused word and an unbroken run of three
    c_pack: cover property (INSTR_VALID && INSTR_WORD == ATD_OP_PACK_E ##1 REG_E_WR);
    c_cfg0: cover property (INSTR_VALID && INSTR_WORD == ATD_OP_OUTCFG0 ##1 PORT_OUTCFG_REG0_WR);
    c_cfg1: cover property (INSTR_VALID && INSTR_WORD == ATD_OP_OUTCFG1 ##1 PORT_OUTCFG_REG1_WR);
    c_refused: cover property (INSTR_VALID && !hit ##1 !EXEC_DONE);
    c_b2b: cover property (EXEC_DONE [*3]);
endmodule : atd_top

// ===== rtl/atd_pkg.sv
package atd_pkg;
    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int ATD_WORD_W = 10;
    localparam int ATD_NIB_W = 4;
    localparam int ATD_E_W = 8;

    // ----------------------------------------
    // opcodes, bits D9..D0
    // ----------------------------------------
    localparam logic [ATD_WORD_W-1:0] ATD_OP_PACK_E = 10'h01a;
    localparam logic [ATD_WORD_W-1:0] ATD_OP_OUTCFG0 = 10'h228;
    localparam logic [ATD_WORD_W-1:0] ATD_OP_OUTCFG1 = 10'h229;

    // ----------------------------------------
    // field positions of register e
    // ----------------------------------------
    localparam int ATD_E_HI_LSB = 4;
    localparam int ATD_E_LO_LSB = 0;

    // ----------------------------------------
    // reset values and timing
    // ----------------------------------------
    localparam logic [ATD_E_W-1:0] ATD_E_RST = 8'h00;
    localparam logic [ATD_NIB_W-1:0] ATD_OUTCFG_RST = 4'h0;
    localparam int ATD_EXEC_CYCLES = 1;
    localparam int ATD_PROG_WORDS = 1;

    typedef enum logic [3:0] {
        ATD_SEL_NONE = 4'h1,
        ATD_SEL_PACK_E = 4'h2,
        ATD_SEL_OUTCFG0 = 4'h4,
        ATD_SEL_OUTCFG1 = 4'h8
    } atd_sel_t;
endpackage : atd_pkg

// ===== rtl/atd_dec_if.sv
`timescale 1ns/100ps
interface atd_dec_if;
    import atd_pkg::*;
    logic [ATD_WORD_W-1:0] word;
    logic valid;
    atd_sel_t sel;

    modport dec (input word, input valid, output sel);
    modport exe (output word, output valid, input sel);
endinterface : atd_dec_if

// ===== rtl/atd_decode.sv
`timescale 1ns/100ps
module atd_decode
    import atd_pkg::*;
(
    atd_dec_if.dec dif
);
    // ----------------------------------------
    // full ten-bit compare; no partial decode
    // ----------------------------------------
    always_comb begin
        dif.sel = ATD_SEL_NONE;
        if (dif.valid) begin
            case (dif.word)
                ATD_OP_PACK_E: dif.sel = ATD_SEL_PACK_E;
                ATD_OP_OUTCFG0: dif.sel = ATD_SEL_OUTCFG0;
                ATD_OP_OUTCFG1: dif.sel = ATD_SEL_OUTCFG1;
                default: dif.sel = ATD_SEL_NONE;
            endcase
        end
    end
endmodule : atd_decode

// ===== test/atd_top_bench.sv
`timescale 1ns/100ps
module atd_top_bench;
    import atd_pkg::*;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic instr_valid = 1'b0;
    logic [ATD_WORD_W-1:0] instr_word = 10'h000;
    logic [ATD_NIB_W-1:0] acc_data = 4'h0;
    logic [ATD_NIB_W-1:0] reg_b_data = 4'h0;
    logic [ATD_E_W-1:0] reg_e;
    logic [ATD_NIB_W-1:0] cfg0, cfg1;
    logic reg_e_wr, cfg0_wr, cfg1_wr, exec_done, carry_we, skip_next;
    logic [ATD_WORD_W-1:0] bad_words [5] = '{10'h01b, 10'h22a, 10'h028, 10'h209, 10'h3ff};
    int miscompares = 0;
    int n_tests = 0;

    always #2.5 core_clk = ~core_clk;

    atd_top dut (
        .CORE_CLK(core_clk), .RST_N(rst_n),
        .INSTR_VALID(instr_valid), .INSTR_WORD(instr_word),
        .ACC_DATA(acc_data), .REG_B_DATA(reg_b_data),
        .REG_E(reg_e), .REG_E_WR(reg_e_wr),
        .PORT_OUTCFG_REG0(cfg0), .PORT_OUTCFG_REG1(cfg1),
        .PORT_OUTCFG_REG0_WR(cfg0_wr), .PORT_OUTCFG_REG1_WR(cfg1_wr),
        .EXEC_DONE(exec_done), .CARRY_FLAG_WE(carry_we), .SKIP_NEXT(skip_next)
    );

    // ----------------------------------------
    // drivers and comparison
    // ----------------------------------------
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            miscompares++;
        end
    endtask : chk

    // pulses packed as {e_wr, cfg0_wr, cfg1_wr, done}
    task automatic chk_out(logic [7:0] e, logic [3:0] c0, logic [3:0] c1, logic [3:0] p);
        chk("reg_e", e, reg_e);
        chk("outcfg0", {4'h0, c0}, {4'h0, cfg0});
        chk("outcfg1", {4'h0, c1}, {4'h0, cfg1});
        chk("pulses", {4'h0, p}, {4'h0, reg_e_wr, cfg0_wr, cfg1_wr, exec_done});
        chk("carry_skip", 8'h00, {6'h00, carry_we, skip_next});
    endtask : chk_out

    // sources are inverted after the taking edge so a late sample shows up
    task automatic put(logic [ATD_WORD_W-1:0] w, logic [3:0] a, logic [3:0] b);
        @(posedge core_clk);
        instr_valid <= 1'b1;
        instr_word <= w;
        acc_data <= a;
        reg_b_data <= b;
    endtask : put

    task automatic idle();
        @(posedge core_clk);
        instr_valid <= 1'b0;
        acc_data <= ~acc_data;
        reg_b_data <= ~reg_b_data;
        #1;
    endtask : idle

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_single();
        put(ATD_OP_PACK_E, 4'h5, 4'ha);
        idle();
        chk_out(8'ha5, 4'h0, 4'h0, 4'b1001);
        idle();
        chk_out(8'ha5, 4'h0, 4'h0, 4'b0000);
        put(ATD_OP_OUTCFG0, 4'h3, 4'hc);
        idle();
        chk_out(8'ha5, 4'h3, 4'h0, 4'b0101);
        put(ATD_OP_OUTCFG1, 4'h9, 4'h6);
        idle();
        chk_out(8'ha5, 4'h3, 4'h9, 4'b0011);
    endtask : t_single

    task automatic t_back_to_back();
        put(ATD_OP_PACK_E, 4'hc, 4'h3);
        put(ATD_OP_OUTCFG0, 4'hf, 4'h0);
        #1;
        chk_out(8'h3c, 4'h3, 4'h9, 4'b1001);
        put(ATD_OP_OUTCFG1, 4'h6, 4'h1);
        #1;
        chk_out(8'h3c, 4'hf, 4'h9, 4'b0101);
        idle();
        chk_out(8'h3c, 4'hf, 4'h6, 4'b0011);
        idle();
        chk_out(8'h3c, 4'hf, 4'h6, 4'b0000);
    endtask : t_back_to_back

    // near-miss words and a valid-low pack must leave everything alone
    task automatic t_refused();
        foreach (bad_words[i]) begin
            put(bad_words[i], 4'h1, 4'h2);
            idle();
            chk_out(8'h3c, 4'hf, 4'h6, 4'b0000);
        end
        @(posedge core_clk);
        instr_word <= ATD_OP_PACK_E;
        idle();
        chk_out(8'h3c, 4'hf, 4'h6, 4'b0000);
    endtask : t_refused

    task automatic t_reset();
        @(posedge core_clk);
        rst_n <= 1'b0;
        #1;
        chk_out(8'h00, 4'h0, 4'h0, 4'b0000);
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        put(ATD_OP_OUTCFG1, 4'h8, 4'h7);
        idle();
        chk_out(8'h00, 4'h0, 4'h8, 4'b0011);
    endtask : t_reset

    // ----------------------------------------
    // verdict and main sequence
    // ----------------------------------------
    task automatic results();
        if (miscompares == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    initial begin
        // the whole sequence needs well under 100 cycles
        #2000;
        miscompares++;
        results();
    end

    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        chk_out(8'h00, 4'h0, 4'h0, 4'b0000);
        t_single();
        t_back_to_back();
        t_refused();
        t_reset();
        results();
    end
endmodule : atd_top_bench
